/* File: core/amp_ctrl_pkg.sv */
// Package for the amplifier protection, clock and PWM control core.
// Assumes one 200 MHz clock domain and 32-bit APB register access.
package amp_ctrl_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_ERR_STATUS = 8'h02;
   localparam logic [7:0] OFF_VOLUME     = 8'h0E;
   localparam logic [7:0] OFF_OC_RETRY   = 8'h1C;
   localparam logic [7:0] OFF_PWM_CFG    = 8'h40;
   localparam logic [7:0] OFF_CLK_STATUS = 8'h44;
   localparam logic [7:0] OFF_ADDR_INFO  = 8'h48;
   // Error status bit positions
   localparam int ERR_OC   = 0;
   localparam int ERR_OT   = 1;
   localparam int ERR_OVLO = 2;
   localparam int ERR_UVLO = 3;
   localparam int ERR_CLK  = 4;
   // Volume register: soft unmute select
   localparam int VOL_SOFT_BIT = 0;
   // PWM configuration layout
   localparam int PWM_DCB_LSB  = 0;
   localparam int PWM_DEEM_LSB = 3;
   localparam int PWM_LIM_LSB  = 6;
   // Bus addresses selected by the strap
   localparam logic [6:0] BUS_ADDR_HIGH = 7'h1B;
   localparam logic [6:0] BUS_ADDR_LOW  = 7'h1A;
   // Reset values
   localparam logic [31:0] RST_VOLUME   = 32'h0000_0000;
   localparam logic [31:0] RST_OC_RETRY = 32'h0000_0400;
   localparam logic [31:0] RST_PWM_CFG  = 32'h0000_0007;
   // Modulation limit codes: 0 is 93.8 %, 7 is 99.2 %
   localparam logic [2:0] MOD_LIM_MIN = 3'h0;
   localparam logic [2:0] MOD_LIM_MAX = 3'h7;
   // Frame tracking
   localparam int BCLK_RATIO_32    = 32;
   localparam int BCLK_RATIO_48    = 48;
   localparam int BCLK_RATIO_64    = 64;
   localparam int FRAME_DRIFT_MAX  = 4;
   localparam int CLK_LOSS_NS      = 2000;
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int CLK_LOSS_CYC     = (CLK_LOSS_NS * 1000) / CLK_PERIOD_PS;
   localparam int PROC_CLK_RATIO   = 512;
   localparam int STRAP_SETTLE_CYC = 8;
   localparam int RAMP_STEP_CYC    = 16;

   typedef enum logic [3:0] {
      ST_RUN     = 4'b0001,
      ST_OC_OFF  = 4'b0010,
      ST_OC_WAIT = 4'b0100,
      ST_HOLD    = 4'b1000
   } prot_state_t;

   typedef struct packed {
      logic       valid;
      logic [6:0] ratio;
      logic       use_osc;
   } clk_info_t;

   typedef struct packed {
      logic overcurrent;
      logic over_temp;
      logic temp_cool;
      logic over_volt;
      logic power_stage_uv;
      logic analog_uv;
   } sense_t;
endpackage

/* File: core/amp_ctrl.sv */
// Control core: address strap, fault pin, protection, clock checking, PWM setup.
// Assumes analog comparators arrive as asynchronous levels and serial clocks are
// sampled by the 200 MHz clock; registers sit on an APB slave.
`timescale 1ns/1ps
module amp_ctrl #(
   parameter int NUM_CH = 3
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_arst_n,
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [7:0]           i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic      [31:0]          o_prdata,
   output logic                      o_pready,
   output logic                      o_pslverr,
   input  wire logic                 i_addr_fault_in,
   output logic                      o_addr_fault_out,
   output logic                      o_addr_fault_oe_n,
   input  wire amp_ctrl_pkg::sense_t i_sense,
   input  wire logic                 i_power_stage_good,
   input  wire logic                 i_analog_good,
   input  wire logic                 i_bit_clk,
   input  wire logic                 i_frame_clk,
   input  wire logic                 i_serial_audio_in,
   output logic      [6:0]           o_bus_addr,
   output logic                      o_bridge_hiz,
   output logic                      o_mute,
   output logic      [7:0]           o_volume_gain,
   output logic                      o_use_osc,
   output logic      [6:0]           o_bclk_ratio,
   output logic      [NUM_CH-1:0]    o_dc_block_en,
   output logic      [NUM_CH-1:0]    o_deemph_en,
   output logic      [2:0]           o_mod_limit,
   output logic      [23:0]          o_sample,
   output logic                      o_sample_valid
);
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) rst_sync <= 2'b00;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // Three-stage samplers; a change counts once stages two and three agree
   localparam int NS = 12;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s1;
   logic [NS-1:0] s2;
   logic [NS-1:0] s3;
   logic [NS-1:0] pin_q;
   assign pin_raw = {i_addr_fault_in, i_sense, i_power_stage_good, i_analog_good,
                     i_bit_clk, i_frame_clk, i_serial_audio_in};
   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_sync
         always_ff @(posedge i_ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1[g]    <= 1'b0;
               s2[g]    <= 1'b0;
               s3[g]    <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               s1[g] <= pin_raw[g];
               s2[g] <= s1[g];
               s3[g] <= s2[g];
               if (s2[g] == s3[g]) pin_q[g] <= s3[g];
            end
         end
      end
   endgenerate
   logic strap_lvl, s_oc, s_ot, s_cool, s_ov, s_puv, s_auv, pgood, agood, bclk, fclk, serial_audio_in;
   assign {strap_lvl, s_oc, s_ot, s_cool, s_ov, s_puv, s_auv, pgood, agood, bclk, fclk, serial_audio_in} = pin_q;

   // Strap capture after the samplers have settled
   logic [3:0] settle_cnt;
   logic       strap_done;
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt <= 4'h0;
         strap_done <= 1'b0;
         o_bus_addr <= amp_ctrl_pkg::BUS_ADDR_LOW;
      end else if (!strap_done) begin
         settle_cnt <= settle_cnt + 4'h1;
         if (settle_cnt == 4'(amp_ctrl_pkg::STRAP_SETTLE_CYC)) begin
            strap_done <= 1'b1;
            o_bus_addr <= strap_lvl ? amp_ctrl_pkg::BUS_ADDR_HIGH : amp_ctrl_pkg::BUS_ADDR_LOW;
         end
      end
   end

   // Supply monitor: the bridges stay off until both supplies are good
   logic supplies_ok;
   assign supplies_ok = pgood && agood && !s_puv && !s_auv;

   // Register storage, declared early since the clock error logic reads it
   logic [31:0] volume;
   logic [31:0] pwm_cfg;

   // Thermal latch clears only on the cool comparator, giving the hysteresis
   // A brief dip of the hot comparator alone never ends a shutdown
   logic thermal_sd;
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) thermal_sd <= 1'b0;
      else if (s_ot) thermal_sd <= 1'b1;
      else if (s_cool) thermal_sd <= 1'b0;
   end

   // Overcurrent shutdown and retry
   // Every expired retry period makes one real restart attempt through RUN;
   // a persisting fault is caught there again, so the bridges pulse briefly
   // Retry counts in core clock cycles, so software scales it to its need
   logic [31:0] oc_retry;
   logic [31:0] oc_cnt;
   amp_ctrl_pkg::prot_state_t pstate;
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pstate <= amp_ctrl_pkg::ST_HOLD;
         oc_cnt <= 32'h0000_0000;
      end else begin
         unique case (pstate)
            amp_ctrl_pkg::ST_HOLD: if (supplies_ok && strap_done) pstate <= amp_ctrl_pkg::ST_RUN;
            amp_ctrl_pkg::ST_RUN: begin
               if (!supplies_ok) pstate <= amp_ctrl_pkg::ST_HOLD;
               else if (s_oc) pstate <= amp_ctrl_pkg::ST_OC_OFF;
            end
            amp_ctrl_pkg::ST_OC_OFF: begin
               oc_cnt <= 32'h0000_0000;
               pstate <= amp_ctrl_pkg::ST_OC_WAIT;
            end
            amp_ctrl_pkg::ST_OC_WAIT: begin
               oc_cnt <= oc_cnt + 32'h0000_0001;
               if (oc_cnt >= oc_retry) pstate <= amp_ctrl_pkg::ST_RUN;
            end
            default: pstate <= amp_ctrl_pkg::ST_HOLD;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) o_bridge_hiz <= 1'b1;
      // One shared enable covers all four half-bridges
      // Overcurrent acts through the state machine so a restart attempt shows
      else o_bridge_hiz <= (pstate != amp_ctrl_pkg::ST_RUN) || thermal_sd || !supplies_ok;
   end

   // Serial clock checking: count bit clocks per frame
   logic bclk_d, fclk_d;
   logic [6:0] bcnt;
   logic [2:0] last_ratio_ok;
   logic       ratio_ok;
   logic [15:0] loss_cnt;
   logic [3:0]  drift_cnt;
   logic        bclk_rise, fclk_rise;
   assign bclk_rise = bclk && !bclk_d;
   assign fclk_rise = fclk && !fclk_d;
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_d <= 1'b0;
         fclk_d <= 1'b0;
         bcnt <= 7'h00;
         o_bclk_ratio <= 7'h00;
         ratio_ok <= 1'b0;
         last_ratio_ok <= 3'h0;
         loss_cnt <= 16'h0000;
         drift_cnt <= 4'h0;
      end else begin
         bclk_d <= bclk;
         fclk_d <= fclk;
         if (bclk_rise) loss_cnt <= 16'h0000;
         else if (loss_cnt != 16'(amp_ctrl_pkg::CLK_LOSS_CYC)) loss_cnt <= loss_cnt + 16'h0001;
         if (fclk_rise) begin
            bcnt <= 7'(bclk_rise);
            o_bclk_ratio <= bcnt;
            if (bcnt == 7'(amp_ctrl_pkg::BCLK_RATIO_32) || bcnt == 7'(amp_ctrl_pkg::BCLK_RATIO_48)
                || bcnt == 7'(amp_ctrl_pkg::BCLK_RATIO_64)) begin
               if (bcnt == o_bclk_ratio) last_ratio_ok <= {last_ratio_ok[1:0], 1'b1};
               else last_ratio_ok <= 3'h1;
               drift_cnt <= 4'h0;
            end else begin
               last_ratio_ok <= 3'h0;
               if (drift_cnt != 4'hF) drift_cnt <= drift_cnt + 4'h1;
            end
         end else if (bclk_rise && bcnt != 7'h7F) bcnt <= bcnt + 7'h01;
         if (loss_cnt == 16'(amp_ctrl_pkg::CLK_LOSS_CYC)) last_ratio_ok <= 3'h0;
         // Beyond the drift allowance tracking restarts from scratch
         if (drift_cnt > 4'(amp_ctrl_pkg::FRAME_DRIFT_MAX)) begin
            last_ratio_ok <= 3'h0;
            drift_cnt <= 4'h0;
         end
         ratio_ok <= (last_ratio_ok == 3'h7);
      end
   end

   // Clock error handling; the bit clock can double as the master clock
   logic       clk_err;
   logic [3:0] ramp_div;
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_err <= 1'b1;
         o_mute <= 1'b1;
         o_use_osc <= 1'b1;
         o_volume_gain <= 8'h00;
         ramp_div <= 4'h0;
      end else begin
         clk_err <= !ratio_ok;
         if (!ratio_ok) begin
            o_mute <= 1'b1;
            o_use_osc <= 1'b1;
            o_volume_gain <= 8'h00;
         end else begin
            o_mute <= 1'b0;
            o_use_osc <= 1'b0;
            ramp_div <= ramp_div + 4'h1;
            if (!volume[amp_ctrl_pkg::VOL_SOFT_BIT]) o_volume_gain <= 8'hFF;
            else if (ramp_div == 4'(amp_ctrl_pkg::RAMP_STEP_CYC - 1) && o_volume_gain != 8'hFF)
               o_volume_gain <= o_volume_gain + 8'h01;
         end
      end
   end

   // Serial sample capture: 24 MSB-first bits after each frame edge
   // Limitation: at 32 bit clocks per frame a half frame holds only 16 bits,
   // so no full sample is taken at that ratio
   logic [23:0] shreg;
   logic [4:0]  bitn;
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= 24'h00_0000;
         bitn <= 5'h00;
         o_sample <= 24'h00_0000;
         o_sample_valid <= 1'b0;
      end else begin
         o_sample_valid <= 1'b0;
         if (fclk_rise || fclk != fclk_d) bitn <= 5'h00;
         else if (bclk_rise && bitn != 5'h18) begin
            shreg <= {shreg[22:0], serial_audio_in};
            bitn <= bitn + 5'h01;
            if (bitn == 5'h17) begin
               o_sample <= {shreg[22:0], serial_audio_in};
               o_sample_valid <= ratio_ok;
            end
         end
      end
   end

   // Registers and error status; hardware set wins over software clear
   logic [4:0]  err_stat;
   logic [4:0]  err_set;
   logic        wr_en, rd_en;
   assign wr_en = i_psel && i_penable && i_pwrite;
   assign rd_en = i_psel && !i_penable && !i_pwrite;
   assign err_set = {clk_err, !supplies_ok && strap_done, s_ov, thermal_sd, s_oc};
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) err_stat <= 5'h00;
      else if (wr_en && i_paddr == amp_ctrl_pkg::OFF_ERR_STATUS) err_stat <= err_set;
      else err_stat <= err_stat | err_set;
   end
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         volume <= amp_ctrl_pkg::RST_VOLUME;
         oc_retry <= amp_ctrl_pkg::RST_OC_RETRY;
         pwm_cfg <= amp_ctrl_pkg::RST_PWM_CFG;
      end else if (wr_en) begin
         if (i_paddr == amp_ctrl_pkg::OFF_VOLUME) volume <= i_pwdata;
         if (i_paddr == amp_ctrl_pkg::OFF_OC_RETRY) oc_retry <= i_pwdata;
         if (i_paddr == amp_ctrl_pkg::OFF_PWM_CFG) pwm_cfg <= {23'h00_0000, i_pwdata[8:0]};
      end
   end
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_dc_block_en <= '0;
         o_deemph_en <= '0;
         o_mod_limit <= amp_ctrl_pkg::MOD_LIM_MIN;
      end else begin
         o_dc_block_en <= pwm_cfg[amp_ctrl_pkg::PWM_DCB_LSB +: NUM_CH];
         o_deemph_en <= pwm_cfg[amp_ctrl_pkg::PWM_DEEM_LSB +: NUM_CH];
         o_mod_limit <= pwm_cfg[amp_ctrl_pkg::PWM_LIM_LSB +: 3];
      end
   end
   // APB: one wait-free access phase; reads answer from the setup cycle
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_prdata <= 32'h0000_0000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= 1'b0;
         if (i_psel && !i_penable) begin
            unique case (i_paddr)
               amp_ctrl_pkg::OFF_ERR_STATUS: o_prdata <= {27'h000_0000, err_stat};
               amp_ctrl_pkg::OFF_VOLUME:     o_prdata <= volume;
               amp_ctrl_pkg::OFF_OC_RETRY:   o_prdata <= oc_retry;
               amp_ctrl_pkg::OFF_PWM_CFG:    o_prdata <= pwm_cfg;
               amp_ctrl_pkg::OFF_CLK_STATUS: o_prdata <= {23'h00_0000, o_use_osc, ratio_ok, o_bclk_ratio};
               amp_ctrl_pkg::OFF_ADDR_INFO:  o_prdata <= {25'h000_0000, o_bus_addr};
               default: begin
                  o_prdata <= 32'h0000_0000;
                  o_pslverr <= rd_en || i_pwrite;
               end
            endcase
         end
      end
   end

   // Fault pin: pin is released until the strap is taken, then driven low on any error except a clock error
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_addr_fault_out <= 1'b1;
         o_addr_fault_oe_n <= 1'b1;
      end else begin
         o_addr_fault_out <= 1'b0;
         o_addr_fault_oe_n <= !(strap_done && (err_stat[3:0] != 4'h0));
      end
   end
endmodule

/* File: tb/amp_ctrl_sva.sv */
// Checker for the control core: bus handshake, fault pin, protection, clock mute.
// Assumes it is bound onto the core's top ports, all in one clock domain.
`timescale 1ns/1ps
module amp_ctrl_sva (
   input wire logic                 i_ref_clk,
   input wire logic                 i_arst_n,
   input wire logic                 i_psel,
   input wire logic                 i_penable,
   input wire logic                 i_pwrite,
   input wire logic [7:0]           i_paddr,
   input wire logic                 o_pready,
   input wire logic                 o_pslverr,
   input wire logic                 o_addr_fault_out,
   input wire logic                 o_addr_fault_oe_n,
   input wire amp_ctrl_pkg::sense_t i_sense,
   input wire logic                 i_power_stage_good,
   input wire logic                 i_analog_good,
   input wire logic                 o_bridge_hiz,
   input wire logic                 o_mute,
   input wire logic                 o_use_osc,
   input wire logic [6:0]           o_bclk_ratio,
   input wire logic                 o_sample_valid
);
   logic [5:0] up_cnt;
   logic       wr_clr;
   // Clearing lands two edges late, so the hold check skips those edges
   assign wr_clr = i_psel && i_penable && i_pwrite && i_paddr == amp_ctrl_pkg::OFF_ERR_STATUS;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         up_cnt <= 6'h00;
      end else if (up_cnt != 6'h3F) begin
         up_cnt <= up_cnt + 6'h01;
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   setup_ready_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready");
   slverr_ready_a: assert property (o_pslverr |-> o_pready) else $error("lone slverr");
   fault_idle_a: assert property (up_cnt > 6'h04 |-> !o_addr_fault_out)
      else $error("pin driven high");
   fault_hold_a: assert property (!o_addr_fault_oe_n && !wr_clr && !$past(wr_clr) |=> !o_addr_fault_oe_n)
      else $error("fault released early");
   ot_fault_a: assert property (i_sense.over_temp && up_cnt > 6'h18
      |-> ##[1:12] (o_bridge_hiz && !o_addr_fault_oe_n)) else $error("no thermal stop");
   uv_hiz_a: assert property (i_sense.power_stage_uv || i_sense.analog_uv |-> ##[1:8] o_bridge_hiz)
      else $error("no uv stop");
   por_hold_a: assert property (!i_power_stage_good || !i_analog_good |-> ##[1:8] o_bridge_hiz)
      else $error("no supply hold");
   oc_hiz_a: assert property (i_sense.overcurrent |-> ##[1:8] o_bridge_hiz)
      else $error("no oc stop");
   bad_ratio_a: assert property (!(o_bclk_ratio inside {7'h20, 7'h30, 7'h40}) |-> ##[0:4] o_mute)
      else $error("bad ratio unmuted");
   mute_osc_a: assert property ($rose(o_mute) |-> ##[0:3] o_use_osc)
      else $error("no osc on mute");
   cover property (o_pslverr);
   cover property ($fell(o_mute));
   cover property ($rose(o_bridge_hiz));
   cover property (o_sample_valid);
endmodule
bind amp_ctrl amp_ctrl_sva amp_ctrl_sva_i (.i_ref_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .o_pready, .o_pslverr, .o_addr_fault_out, .o_addr_fault_oe_n, .i_sense, .i_power_stage_good,
   .i_analog_good, .o_bridge_hiz, .o_mute, .o_use_osc, .o_bclk_ratio, .o_sample_valid);

/* File: tb/audio_host_model.sv */
// Host audio source: bit clock, frame clock and serial data, MSB first.
// Assumes the ratio is set before running; the bit clock stands low when idle.
`timescale 1ns/1ps
module audio_host_model (
   input  wire logic        i_run,
   input  wire logic [6:0]  i_ratio,
   input  wire logic [23:0] i_word,
   output logic             o_bit_clk,
   output logic             o_frame_clk,
   output logic             o_data
);
   int pos = 0;
   initial begin
      o_bit_clk = 1'b0;
      o_frame_clk = 1'b0;
      o_data = 1'b0;
   end
   // Frame and data move on the falling edge, stable at the rising edge
   always begin
      #40;
      if (i_run) begin
         o_bit_clk = 1'b1;
         #40;
         o_bit_clk = 1'b0;
         pos = (pos + 1) % (i_ratio / 2);
         if (pos == 0) o_frame_clk = ~o_frame_clk;
         o_data = (pos < 24) ? i_word[23 - pos] : ~o_data;
      end
   end
endmodule

/* File: tb/test_amp_ctrl.sv */
// Bench for the control core: APB sequences, protection inputs, audio clocks.
// Assumes the host model drives the serial clocks at an 80 ns bit period.
`timescale 1ns/1ps
module test_amp_ctrl;
   logic                 i_ref_clk = 1'b0, i_arst_n = 1'b0, strap = 1'b1, run = 1'b0, err;
   logic                 i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic                 i_power_stage_good = 1'b1, i_analog_good = 1'b1;
   logic [7:0]           i_paddr = 8'h00, o_volume_gain;
   logic [31:0]          i_pwdata = 32'h0000_0000, o_prdata, rd, v;
   logic                 o_pready, o_pslverr, o_addr_fault_out, o_addr_fault_oe_n;
   logic                 o_bridge_hiz, o_mute, o_use_osc, o_sample_valid;
   amp_ctrl_pkg::sense_t i_sense = 6'h00;
   wire                  i_addr_fault_in, i_bit_clk, i_frame_clk, i_serial_audio_in;
   logic [6:0]           o_bus_addr, o_bclk_ratio, want = 7'h40;
   logic [2:0]           o_dc_block_en, o_deemph_en, o_mod_limit;
   logic [23:0]          o_sample;
   int                   n_fail = 0, checked = 0, k;
   always #2.5 i_ref_clk = ~i_ref_clk;
   // Strap resistor sets the level unless the core pulls the pin
   assign i_addr_fault_in = (o_addr_fault_oe_n === 1'b0) ? o_addr_fault_out : strap;
   amp_ctrl amp_ctrl_i (.i_ref_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_addr_fault_in, .o_addr_fault_out, .o_addr_fault_oe_n,
      .i_sense, .i_power_stage_good, .i_analog_good, .i_bit_clk, .i_frame_clk, .i_serial_audio_in,
      .o_bus_addr, .o_bridge_hiz, .o_mute, .o_volume_gain, .o_use_osc, .o_bclk_ratio,
      .o_dc_block_en, .o_deemph_en, .o_mod_limit, .o_sample, .o_sample_valid);
   audio_host_model audio_host_model_i (.i_run(run), .i_ratio(want), .i_word(24'h5A_C396),
      .o_bit_clk(i_bit_clk), .o_frame_clk(i_frame_clk), .o_data(i_serial_audio_in));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic hit(input int w);
      case (w)
         0: return o_bridge_hiz;
         1: return !o_bridge_hiz;
         2: return !o_mute && o_bclk_ratio === want;
         3: return o_mute;
         4: return o_sample_valid;
         default: return o_volume_gain === 8'hFF;
      endcase
   endfunction
   task automatic wait_for(input int w, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (hit(w) !== 1'b1 && n < lim);
      if (hit(w) !== 1'b1) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (o_pready !== 1'b1) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic clear_fault(input int b);
      check(o_addr_fault_oe_n, 1'b0);
      apb(1'b0, amp_ctrl_pkg::OFF_ERR_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_000F, 32'h0000_0001 << b);
      apb(1'b1, amp_ctrl_pkg::OFF_ERR_STATUS, 32'h0000_0000);
      repeat (3) @(posedge i_ref_clk);
      check(o_addr_fault_oe_n, 1'b1);
   endtask
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      repeat (30) @(posedge i_ref_clk);
      check(o_bus_addr, 7'b0011011);
      apb(1'b0, amp_ctrl_pkg::OFF_OC_RETRY, 32'h0000_0000);
      check(rd, amp_ctrl_pkg::RST_OC_RETRY);
      apb(1'b0, amp_ctrl_pkg::OFF_PWM_CFG, 32'h0000_0000);
      check(rd, amp_ctrl_pkg::RST_PWM_CFG);
      apb(1'b0, 8'h10, 32'h0000_0000);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      strap <= 1'b0;
      repeat (30) @(posedge i_ref_clk);
      check(o_bus_addr, 7'b0011011);
      i_arst_n <= 1'b0;
      repeat (10) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      repeat (30) @(posedge i_ref_clk);
      check(o_bus_addr, 7'b0011010);
      $display("strap test done");
      apb(1'b1, amp_ctrl_pkg::OFF_OC_RETRY, 32'h0000_0010);
      i_sense.overcurrent <= 1'b1;
      wait_for(0, 12);
      i_sense.overcurrent <= 1'b0;
      for (k = 0; k < 200 && o_bridge_hiz === 1'b1; k++) @(posedge i_ref_clk);
      check(k >= 16 && k < 40, 1'b1);
      i_sense.overcurrent <= 1'b1;
      k = 0;
      repeat (200) @(posedge i_ref_clk) k += (o_bridge_hiz === 1'b0);
      check(k > 0 && k < 100, 1'b1);
      i_sense.overcurrent <= 1'b0;
      wait_for(1, 100);
      clear_fault(amp_ctrl_pkg::ERR_OC);
      i_sense.over_temp <= 1'b1;
      wait_for(0, 12);
      i_sense.over_temp <= 1'b0;
      repeat (20) @(posedge i_ref_clk);
      check(o_bridge_hiz, 1'b1);
      i_sense.temp_cool <= 1'b1;
      wait_for(1, 20);
      i_sense.temp_cool <= 1'b0;
      clear_fault(amp_ctrl_pkg::ERR_OT);
      $display("oc and thermal test done");
      for (k = 0; k < 5; k++) begin
         i_sense.power_stage_uv <= (k == 0);
         i_sense.analog_uv <= (k == 1);
         i_sense.over_volt <= (k == 2);
         i_power_stage_good <= (k != 3);
         i_analog_good <= (k != 4);
         if (k != 2) wait_for(0, 12);
         repeat (12) @(posedge i_ref_clk);
         i_sense <= 6'h00;
         i_power_stage_good <= 1'b1;
         i_analog_good <= 1'b1;
         wait_for(1, 40);
         if (k < 3) clear_fault(k == 2 ? amp_ctrl_pkg::ERR_OVLO : amp_ctrl_pkg::ERR_UVLO);
         else apb(1'b1, amp_ctrl_pkg::OFF_ERR_STATUS, 32'h0000_0000);
      end
      $display("supply test done");
      run <= 1'b1;
      for (k = 0; k < 3; k++) begin
         want <= 7'(64 - 16 * k);
         wait_for(2, 8000);
         check(o_use_osc, 1'b0);
         if (k != 2) begin
            wait_for(4, 3000);
            check(o_sample, 24'h5A_C396);
         end
         check(o_volume_gain, 8'hFF);
      end
      apb(1'b1, amp_ctrl_pkg::OFF_VOLUME, 32'h0000_0001);
      want <= 7'h28;
      wait_for(3, 3000);
      check(o_use_osc, 1'b1);
      repeat (3000) @(posedge i_ref_clk);
      check(o_mute, 1'b1);
      want <= 7'h40;
      wait_for(2, 8000);
      check(o_volume_gain === 8'hFF, 1'b0);
      wait_for(5, 6000);
      $display("audio clock test done");
      for (k = 0; k < 2; k++) begin
         v = k ? 32'h0000_01EA : 32'h0000_0015;
         apb(1'b1, amp_ctrl_pkg::OFF_PWM_CFG, v);
         apb(1'b0, amp_ctrl_pkg::OFF_PWM_CFG, 32'h0000_0000);
         check(rd, v);
         check({o_mod_limit, o_deemph_en, o_dc_block_en}, v[8:0]);
      end
      $display("pwm config test done");
      final_report();
   end
endmodule
